// *** hw/sas_pkg.sv ***
// constants, states and carrier types of the eight-channel converter sequencer
// assumes a 125 MHz system clock and a classic Wishbone register bus
package sas_pkg;
  // clocking: the conversion clock is a tick derived from the system clock
  localparam int unsigned SYS_CLK_HZ = 125_000_000;
  localparam int unsigned CONV_CLK_HZ = 640_000;
  localparam int unsigned CONV_DIV = SYS_CLK_HZ / CONV_CLK_HZ;
  localparam logic [7:0] DIV_LAST = 8'(CONV_DIV - 1);

  // conversion sequence in conversion clock periods
  localparam int unsigned SAMPLE_TICKS = 32;
  localparam int unsigned BIT_TICKS = 4;
  localparam logic [5:0] SAMPLE_LAST = 6'(SAMPLE_TICKS - 1);
  localparam logic [5:0] BIT_LAST = 6'(BIT_TICKS - 1);
  localparam logic [6:0] CONV_MIN_TICKS = 7'd57;
  localparam logic [6:0] CONV_MAX_TICKS = 7'd74;
  localparam logic [6:0] SINCE_MAX = 7'h7f;

  localparam int unsigned NBITS = 8;
  localparam int unsigned NCHAN = 8;
  localparam logic [7:0] WEIGHT_MSB = 8'h80;
  localparam logic [7:0] SEL_RST = 8'h01;

  // register map, byte addresses
  localparam int unsigned ADR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;

  // field positions
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_LOOP_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_EOC_BIT = 1;
  localparam int unsigned STAT_CHAN_LSB = 8;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_ABORT_BIT = 1;

  // reset values
  localparam logic CTRL_LOOP_RST = 1'b0;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_BIT = 4'b0100,
    ST_LATCH = 4'b1000
  } sas_state_t;

  // pin inputs that travel together through the synchroniser
  typedef struct packed {
    logic [2:0] addr;
    logic ale;
    logic start;
    logic oe;
    logic comp;
  } sas_pins_t;
endpackage : sas_pkg

// *** hw/sas_adc_seq.sv ***
// control logic of an eight-channel successive-approximation converter
// assumes an external comparator, analog switches driven by o_sel and
// o_trial, a Wishbone classic master and asynchronous pin inputs
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps

// How it works
// - exactly one of eight channel selects is active, from the decoded address.
// - channel address captured on rising edge of address strobe; controller holds it valid.
// - rising edge of start clears the output result latch.
// - sampling starts at start and lasts 32 conversion clock periods.
// - a new start before end of conversion (65 periods) aborts and restarts the conversion.
// - an interrupted conversion's result is discarded, never presented.
// - free-running mode: end of conversion retriggers start for each new conversion.
// - conversion takes 57 to 74 conversion clocks from start to result.
// - end of conversion responds to start within 8 clocks plus 2 us.
// - bits are tried from weight 128 down to the least significant bit.
// - comparator decision writes each bit and keeps or releases that weight.
// - after all eight bits the sequencer returns to the sampling idle phase.
// - result is straight binary: zero input all zeros, full scale all ones.
// - result held in a latch and driven onto three-state data outputs.
module sas_adc_seq (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [sas_pkg::ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [2:0] i_addr,
  input wire logic i_ale,
  input wire logic i_start,
  input wire logic i_oe,
  input wire logic i_comp,
  output logic [sas_pkg::NCHAN-1:0] o_sel,
  output logic [sas_pkg::NBITS-1:0] o_trial,
  output logic [sas_pkg::NBITS-1:0] o_data,
  output logic o_data_oe,
  output logic o_eoc,
  output logic o_irq
);
  import sas_pkg::*;

  logic [1:0] rst_q;
  logic rst_n;
  sas_pins_t pin_raw;
  sas_pins_t pin_m;
  sas_pins_t pin_s;
  sas_pins_t pin_d;

  sas_state_t state, next_state;
  logic [7:0] div_cnt, next_div_cnt;
  logic [5:0] tick_cnt, next_tick_cnt;
  logic [7:0] weight, next_weight;
  logic [7:0] result, next_result;
  logic [7:0] out_latch, next_out_latch;
  logic eoc, next_eoc;
  logic eoc_q;
  logic [2:0] channel, next_channel;
  logic [7:0] sel, next_sel;
  logic ev_done, ev_abort;

  logic ctrl_loop, next_ctrl_loop;
  logic [1:0] irq_stat, next_irq_stat;
  logic [1:0] irq_mask, next_irq_mask;
  logic wb_ack, next_wb_ack;
  logic [31:0] wb_dat, next_wb_dat;
  logic irq, next_irq;
  logic [7:0] data, next_data;
  logic data_oe, next_data_oe;

  logic tick, ale_rise, ext_start, sw_start, loop_start, start_evt, decide;
  logic wb_commit, wr_commit, rd_commit;
  logic [6:0] since;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // pin synchroniser; only pin_s and later stages feed logic
  assign pin_raw = '{addr: i_addr, ale: i_ale, start: i_start, oe: i_oe, comp: i_comp};
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_m <= '0;
      pin_s <= '0;
      pin_d <= '0;
    end else begin
      pin_m <= pin_raw;
      pin_s <= pin_m;
      pin_d <= pin_s;
    end
  end

  // bus commit happens on the edge where the master sees ack
  assign wb_commit = i_wb_cyc & i_wb_stb & wb_ack;
  assign wr_commit = wb_commit & i_wb_we & i_wb_sel[0];
  assign rd_commit = wb_commit & ~i_wb_we;

  assign tick = (div_cnt == DIV_LAST);
  assign ale_rise = pin_s.ale & ~pin_d.ale;
  assign ext_start = pin_s.start & ~pin_d.start;
  assign sw_start = wr_commit & (i_wb_adr == REG_CTRL) & i_wb_dat[CTRL_START_BIT];
  assign loop_start = ctrl_loop & eoc & ~eoc_q;
  assign start_evt = ext_start | sw_start | loop_start;
  assign decide = (state == ST_BIT) & tick & (tick_cnt == BIT_LAST) & ~start_evt;

  // conversion sequencer
  always_comb begin
    next_state = state;
    next_div_cnt = tick ? 8'h00 : 8'(div_cnt + 8'h01);
    next_tick_cnt = tick_cnt;
    next_weight = weight;
    next_result = result;
    next_out_latch = out_latch;
    next_eoc = eoc;
    next_channel = channel;
    ev_done = 1'b0;
    ev_abort = 1'b0;
    if (ale_rise) begin
      next_channel = pin_s.addr;
    end
    next_sel = SEL_RST << next_channel;
    if (start_evt) begin
      next_div_cnt = 8'h00;
      next_state = ST_SAMPLE;
      next_tick_cnt = 6'h00;
      next_weight = 8'h00;
      next_result = 8'h00;
      next_out_latch = 8'h00;
      next_eoc = 1'b0;
      ev_abort = (state != ST_IDLE);
    end else if (tick) begin
      case (state)
        ST_IDLE: begin
          next_tick_cnt = 6'h00;
        end
        ST_SAMPLE: begin
          if (tick_cnt == SAMPLE_LAST) begin
            next_state = ST_BIT;
            next_tick_cnt = 6'h00;
            next_weight = WEIGHT_MSB;
            next_result = WEIGHT_MSB;
          end else begin
            next_tick_cnt = 6'(tick_cnt + 6'h01);
          end
        end
        ST_BIT: begin
          if (tick_cnt == BIT_LAST) begin
            next_tick_cnt = 6'h00;
            // comparator low releases the weight, high keeps it
            next_result = pin_s.comp ? result : (result & ~weight);
            next_weight = weight >> 1;
            if (weight[0]) begin
              next_state = ST_LATCH;
            end else begin
              next_result = next_result | (weight >> 1);
            end
          end else begin
            next_tick_cnt = 6'(tick_cnt + 6'h01);
          end
        end
        ST_LATCH: begin
          next_out_latch = result;
          next_eoc = 1'b1;
          next_state = ST_IDLE;
          ev_done = 1'b1;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      div_cnt <= 8'h00;
      tick_cnt <= 6'h00;
      weight <= 8'h00;
      result <= 8'h00;
      out_latch <= 8'h00;
      eoc <= 1'b0;
      eoc_q <= 1'b0;
      channel <= 3'h0;
      sel <= SEL_RST;
    end else begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      tick_cnt <= next_tick_cnt;
      weight <= next_weight;
      result <= next_result;
      out_latch <= next_out_latch;
      eoc <= next_eoc;
      eoc_q <= eoc;
      channel <= next_channel;
      sel <= next_sel;
    end
  end

  // register file, interrupts and output drive
  always_comb begin
    next_ctrl_loop = ctrl_loop;
    next_irq_mask = irq_mask;
    next_wb_ack = i_wb_cyc & i_wb_stb & ~wb_ack;
    next_wb_dat = 32'h0000_0000;
    if (wr_commit && (i_wb_adr == REG_CTRL)) begin
      next_ctrl_loop = i_wb_dat[CTRL_LOOP_BIT];
    end
    if (wr_commit && (i_wb_adr == REG_IRQ_MASK)) begin
      next_irq_mask = i_wb_dat[1:0];
    end
    if (i_wb_cyc && i_wb_stb && !wb_ack && !i_wb_we) begin
      case (i_wb_adr)
        REG_CTRL: next_wb_dat[CTRL_LOOP_BIT] = ctrl_loop;
        REG_STATUS: begin
          next_wb_dat[STAT_BUSY_BIT] = (state != ST_IDLE);
          next_wb_dat[STAT_EOC_BIT] = eoc;
          next_wb_dat[STAT_CHAN_LSB +: 3] = channel;
        end
        REG_RESULT: next_wb_dat[NBITS-1:0] = out_latch;
        REG_IRQ_STAT: next_wb_dat[1:0] = irq_stat;
        REG_IRQ_MASK: next_wb_dat[1:0] = irq_mask;
        default: next_wb_dat = 32'h0000_0000;
      endcase
    end else if (wb_ack) begin
      next_wb_dat = wb_dat;
    end
    // clear only bits that were returned; a new event wins over the clear
    next_irq_stat = irq_stat;
    if (rd_commit && (i_wb_adr == REG_IRQ_STAT)) begin
      next_irq_stat = irq_stat & ~wb_dat[1:0];
    end
    next_irq_stat[IRQ_DONE_BIT] = next_irq_stat[IRQ_DONE_BIT] | ev_done;
    next_irq_stat[IRQ_ABORT_BIT] = next_irq_stat[IRQ_ABORT_BIT] | ev_abort;
    next_irq = |(irq_stat & irq_mask);
    next_data_oe = pin_s.oe;
    next_data = pin_s.oe ? out_latch : 8'h00;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_loop <= CTRL_LOOP_RST;
      irq_mask <= IRQ_MASK_RST;
      irq_stat <= 2'h0;
      wb_ack <= 1'b0;
      wb_dat <= 32'h0000_0000;
      irq <= 1'b0;
      data <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      ctrl_loop <= next_ctrl_loop;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      wb_ack <= next_wb_ack;
      wb_dat <= next_wb_dat;
      irq <= next_irq;
      data <= next_data;
      data_oe <= next_data_oe;
    end
  end

  assign o_wb_ack = wb_ack;
  assign o_wb_dat = wb_dat;
  assign o_sel = sel;
  assign o_trial = result;
  assign o_data = data;
  assign o_data_oe = data_oe;
  assign o_eoc = eoc;
  assign o_irq = irq;

  // conversion clock periods since the last start, for the checks below
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      since <= 7'h00;
    end else if (start_evt) begin
      since <= 7'h00;
    end else if (tick && since != SINCE_MAX) begin
      since <= 7'(since + 7'h01);
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_sample_end;
    (state == ST_SAMPLE) ##1 (state == ST_BIT);
  endsequence

  sequence s_abort;
    start_evt && (state != ST_IDLE);
  endsequence

  sel_onehot_a: assert property ($onehot(o_sel))
    else $error("channel select not one-hot");
  addr_load_a: assert property (ale_rise |=> ##1 o_sel == (SEL_RST << $past(pin_s.addr, 2)))
    else $error("channel address not captured on strobe edge");
  start_clear_a: assert property (start_evt |=> (out_latch == 8'h00) && !o_eoc)
    else $error("start did not clear latch and end of conversion");
  sample_len_a: assert property (s_sample_end |-> since == 7'(SAMPLE_TICKS))
    else $error("sampling phase length wrong");
  restart_a: assert property (s_abort |=> (state == ST_SAMPLE) && irq_stat[IRQ_ABORT_BIT])
    else $error("start during conversion did not restart");
  discard_a: assert property (s_abort |=> (out_latch == 8'h00) [*8])
    else $error("interrupted result presented");
  loop_a: assert property (loop_start |=> state == ST_SAMPLE)
    else $error("free-running mode did not retrigger");
  conv_time_a: assert property ($rose(eoc) |-> since >= CONV_MIN_TICKS && since <= CONV_MAX_TICKS)
    else $error("conversion time out of range");
  eoc_resp_a: assert property (start_evt ##1 !start_evt |-> !o_eoc ##1 !o_eoc)
    else $error("end of conversion did not respond to start");
  msb_first_a: assert property (s_sample_end |-> weight == WEIGHT_MSB && o_trial == WEIGHT_MSB)
    else $error("first trial weight not 128");
  bit_keep_a: assert property (decide && pin_s.comp |=> (result & $past(weight)) != 8'h00)
    else $error("kept bit was released");
  bit_drop_a: assert property (decide && !pin_s.comp |=> (result & $past(weight)) == 8'h00)
    else $error("released bit was kept");
  done_idle_a: assert property ((state == ST_LATCH) && tick && !start_evt |=>
      (state == ST_IDLE) && o_eoc && (out_latch == $past(result)))
    else $error("conversion end did not latch and idle");
  drive_data_a: assert property (pin_s.oe |=> o_data_oe && o_data == $past(out_latch))
    else $error("enabled data output does not show latch");
  float_data_a: assert property (!pin_s.oe |=> !o_data_oe)
    else $error("data output driven without enable");
  // end of conversion may only stand once the sequencer is back in idle
  eoc_low_a: assert property ((state != ST_IDLE) |-> !o_eoc)
    else $error("end of conversion high during conversion");
  // the latch moves only on a start or on the latch tick
  latch_hold_a: assert property ((state != ST_LATCH) && !start_evt |=> $stable(out_latch))
    else $error("result latch changed outside latch step");
endmodule : sas_adc_seq

// *** test/sas_ctrl_model.sv ***
// controller and analog front end on the converter pins
// assumes the sequencer samples its pin inputs on i_clk
`timescale 1ns/100ps
module sas_ctrl_model (
  input wire logic i_clk,
  input wire logic [7:0] i_sel,
  input wire logic [7:0] i_trial,
  output logic [2:0] o_addr,
  output logic o_ale,
  output logic o_start,
  output logic o_comp
);
  logic [7:0] level [8];
  logic [2:0] chan;
  initial begin
    o_addr = 3'h0;
    o_ale = 1'b0;
    o_start = 1'b0;
    foreach (level[i]) level[i] = 8'h00;
  end
  always_comb begin
    chan = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (i_sel[i]) chan = 3'(i);
    end
  end
  // comparator: selected input against the trial code
  assign o_comp = (level[chan] >= i_trial);
  task automatic load_chan(input logic [2:0] ch);
    @(posedge i_clk);
    o_addr <= ch;
    repeat (8) @(posedge i_clk);
    o_ale <= 1'b1;
    repeat (30) @(posedge i_clk);
    o_ale <= 1'b0;
    repeat (8) @(posedge i_clk);
    // released lines show the inverse
    o_addr <= ~ch;
  endtask : load_chan
  task automatic pulse_start();
    @(posedge i_clk);
    o_start <= 1'b1;
    repeat (30) @(posedge i_clk);
    o_start <= 1'b0;
  endtask : pulse_start
endmodule : sas_ctrl_model

// *** test/testbench.sv ***
// self-checking bench for the converter sequencer
// assumes the controller model on the pins and a Wishbone master here
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
  import sas_pkg::*;
  localparam int unsigned TMIN = 57 * CONV_DIV;
  localparam int unsigned TMAX = 74 * CONV_DIV + 10;
  logic clk, rst_n, cyc, stb, we, oe, ack, data_oe, eoc, irq, ale, start, comp;
  logic [7:0] adr, sel_o, trial, data, v, e;
  logic [3:0] bsel;
  logic [31:0] wdat, rdat, rd;
  logic [2:0] addr, ch;
  int fail_count, num_checks, n;

  sas_adc_seq dut (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(bsel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_addr(addr), .i_ale(ale), .i_start(start), .i_oe(oe), .i_comp(comp),
    .o_sel(sel_o), .o_trial(trial), .o_data(data), .o_data_oe(data_oe), .o_eoc(eoc),
    .o_irq(irq));
  sas_ctrl_model model (.i_clk(clk), .i_sel(sel_o), .i_trial(trial), .o_addr(addr),
    .o_ale(ale), .o_start(start), .o_comp(comp));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [7:0] approx_code(input logic [7:0] lvl);
    logic [7:0] r;
    r = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      if (lvl >= (r | (8'h01 << b))) r = r | (8'h01 << b);
    end
    return r;
  endfunction : approx_code

  function automatic logic [7:0] trial2(input logic [7:0] lvl);
    return ((lvl >= 8'h80) ? 8'h80 : 8'h00) | 8'h40;
  endfunction : trial2

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // classic cycle, entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    q = rdat;
    if (k >= 100) begin
      fail_count++;
      $display("mismatch at %0t: no bus answer", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic wait_eoc(input logic lvl, output int cnt);
    cnt = 0;
    while (eoc !== lvl && cnt < TMAX + 100) begin
      @(posedge clk);
      cnt++;
    end
  endtask : wait_eoc

  task automatic do_start(input logic sw);
    if (sw) begin
      wb(1'b1, REG_CTRL, 32'h1, rd);
    end else begin
      fork
        model.pulse_start();
      join_none
    end
  endtask : do_start

  initial begin
    repeat (95000) @(posedge clk);
    fail_count++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, oe} = 4'h0;
    adr = 8'h00;
    bsel = 4'hf;
    wdat = 32'h0;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(77));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(sel_o, SEL_RST)
    `CHK({eoc, data_oe}, 2'b00)
    wb(1'b0, REG_IRQ_MASK, 32'h0, rd);
    `CHK(rd, 32'h0)
    wb(1'b0, REG_CTRL, 32'h0, rd);
    `CHK(rd, {30'h0, CTRL_LOOP_RST, 1'b0})
    wb(1'b0, 8'h20, 32'h0, rd);
    `CHK(rd, 32'h0)
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      ch = (k == 0) ? 3'h7 : (k == 1) ? 3'h0 : 3'($urandom_range(7));
      model.load_chan(ch);
      repeat (6) @(posedge clk);
      `CHK(sel_o, 8'h01 << ch)
      wb(1'b0, REG_STATUS, 32'h0, rd);
      `CHK(rd[10:8], ch)
    end
    $display("test channel done");
    oe <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'($urandom) : 8'h00;
      e = approx_code(v);
      model.level[ch] = v;
      do_start(i == 1);
      repeat (12) @(posedge clk);
      `CHK(data, 8'h00)
      `CHK(eoc, 1'b0)
      repeat (34 * CONV_DIV - 12) @(posedge clk);
      `CHK(trial, WEIGHT_MSB)
      repeat (4 * CONV_DIV) @(posedge clk);
      `CHK(trial, trial2(v))
      wait_eoc(1'b1, n);
      n = n + 38 * CONV_DIV;
      `CHK(n >= TMIN && n <= TMAX, 1'b1)
      // data pins follow the latch one clock after end of conversion
      @(posedge clk);
      `CHK(data, e)
      wb(1'b0, REG_RESULT, 32'h0, rd);
      `CHK(rd[7:0], e)
      wb(1'b0, REG_STATUS, 32'h0, rd);
      `CHK(rd[1:0], 2'b10)
      if (i == 0) begin
        `CHK(irq, 1'b0)
        wb(1'b1, REG_IRQ_MASK, 32'h3, rd);
        repeat (3) @(posedge clk);
      end
      `CHK(irq, 1'b1)
      wb(1'b0, REG_IRQ_STAT, 32'h0, rd);
      `CHK(rd[1:0], 2'b01)
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b0)
      oe <= 1'b0;
      repeat (5) @(posedge clk);
      `CHK({data_oe, data}, 9'h000)
      oe <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK(data_oe, 1'b1)
      $display("test conversion %0d done", i);
    end
    do_start(1'b1);
    repeat (20 * CONV_DIV) @(posedge clk);
    model.level[ch] = 8'h5a;
    do_start(1'b0);
    wait_eoc(1'b1, n);
    `CHK(n >= TMIN - 40, 1'b1)
    @(posedge clk);
    `CHK(data, approx_code(8'h5a))
    wb(1'b0, REG_IRQ_STAT, 32'h0, rd);
    `CHK(rd[1:0], 2'b11)
    $display("test abort done");
    wb(1'b1, REG_CTRL, 32'h3, rd);
    wait_eoc(1'b0, n);
    wait_eoc(1'b1, n);
    `CHK(n >= TMIN - 40 && n <= TMAX, 1'b1)
    repeat (12) @(posedge clk);
    `CHK({eoc, data}, 9'h000)
    wb(1'b1, REG_CTRL, 32'h0, rd);
    $display("test loop done");
    complete_run();
  end
endmodule : testbench
